// >>> logic/iocc_pkg.sv
package iocc_pkg;

  // Command codes delivered by the upstream parser
  typedef enum logic [2:0]
  {
    IOCC_CMD_NONE = 3'h0,
    IOCC_CMD_IDQ = 3'h1,
    IOCC_CMD_OPC = 3'h2,
    IOCC_CMD_OPCQ = 3'h3,
    IOCC_CMD_CLS = 3'h4,
    IOCC_CMD_RST = 3'h5,
    IOCC_CMD_ESRQ = 3'h6,
    IOCC_CMD_OTHER = 3'h7
  } iocc_cmd_t;

  // One parsed program message unit
  typedef struct packed
  {
    logic valid;
    iocc_cmd_t cmd;
  } iocc_unit_t;

  // One reply byte toward the output queue
  typedef struct packed
  {
    logic valid;
    logic last;
    logic [7:0] data;
  } iocc_byte_t;

  // Event status layout
  localparam int IOCC_ESR_W = 8;
  localparam int IOCC_ESR_OPC_BIT = 0;
  localparam int IOCC_ESR_PON_BIT = 7;
  localparam logic [7:0] IOCC_ESR_RESET = 8'h80;

  // Identity reply text; field values arbitrary, not a real maker or part
  localparam int IOCC_ID_LEN = 16;
  localparam logic [8*IOCC_ID_LEN-1:0] IOCC_ID_TEXT = "ACME,MODEL1,0,A1";
  localparam int IOCC_ID_IDX_W = 5;

  // ASCII reply characters
  localparam logic [7:0] IOCC_ASCII_ONE = 8'h31;
  localparam logic [7:0] IOCC_ASCII_ZERO = 8'h30;

  // Longest decimal reply for an 8 bit register
  localparam int IOCC_DEC_DIGITS = 3;

endpackage : iocc_pkg

// >>> logic/iocc_reply_tx.sv
`timescale 1ns/1ps
// Serialises a byte string into the output queue, one byte per accepted beat
module iocc_reply_tx
  import iocc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Load side
  input wire logic load,
  input wire logic [8*IOCC_ID_LEN-1:0] text,
  input wire logic [IOCC_ID_IDX_W-1:0] len,
  // Output queue side
  input wire logic oq_ready,
  output iocc_byte_t oq_byte,
  output logic busy
);

  logic [8*IOCC_ID_LEN-1:0] buf_q, buf_d;
  logic [IOCC_ID_IDX_W-1:0] cnt_q, cnt_d;

  // Shift out the most significant byte first
  always_comb
  begin
    buf_d = buf_q;
    cnt_d = cnt_q;
    if (load)
    begin
      buf_d = text;
      cnt_d = len;
    end
    else if (cnt_q != '0 && oq_ready)
    begin
      buf_d = {buf_q[8*IOCC_ID_LEN-9:0], 8'h00};
      cnt_d = cnt_q - 5'h01;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      buf_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      buf_q <= buf_d;
      cnt_q <= cnt_d;
    end
  end

  assign oq_byte.valid = (cnt_q != '0);
  assign oq_byte.last = (cnt_q == 5'h01);
  assign oq_byte.data = buf_q[8*IOCC_ID_LEN-1 -: 8];
  assign busy = (cnt_q != '0);

endmodule : iocc_reply_tx

// >>> logic/iocc_core.sv
`timescale 1ns/1ps
module iocc_core
  import iocc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Parsed units from the input queue
  input iocc_unit_t unit_in,
  output logic unit_ready,
  input wire logic queue_empty,
  input wire logic work_busy,
  // Device clear active state from the interface
  input wire logic dev_clear,
  // Output queue
  input wire logic oq_ready,
  output iocc_byte_t oq_out,
  // Event status
  output logic [IOCC_ESR_W-1:0] esr,
  output logic opc_pending
);

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_SEND = 3'b100
  } iocc_state_t;

  iocc_state_t state_q, state_d;
  logic pend_q, pend_d;
  logic query_q, query_d;
  logic [IOCC_ESR_W-1:0] esr_q, esr_d;
  logic load;
  logic [8*IOCC_ID_LEN-1:0] text;
  logic [IOCC_ID_IDX_W-1:0] len;
  logic tx_busy;
  logic cancel;
  logic done_now;
  logic take;
  iocc_byte_t tx_byte;
  logic unit_ready_q;
  iocc_byte_t oq_q;

  // Decimal rendering of a register value, left justified
  function automatic logic [8*IOCC_ID_LEN-1:0] dec_text(input logic [7:0] v);
    logic [7:0] h, t, o;
    h = v / 8'd100;
    t = (v / 8'd10) % 8'd10;
    o = v % 8'd10;
    dec_text = '0;
    dec_text[8*IOCC_ID_LEN-1 -: 24] = {IOCC_ASCII_ZERO + h, IOCC_ASCII_ZERO + t,
                                       IOCC_ASCII_ZERO + o};
  endfunction : dec_text

  ////////////////////////////////////////////////////////////////////////////
  // Unit acceptance and cancel conditions

  // Units are held off while a reply drains, so a query never overruns it
  assign take = unit_in.valid && unit_ready_q;
  assign cancel = dev_clear || (take && (unit_in.cmd == IOCC_CMD_CLS
                  || unit_in.cmd == IOCC_CMD_RST));
  // Everything ahead of the completion request has been processed
  assign done_now = pend_q && queue_empty && !work_busy && !tx_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Completion tracking, event status and reply loading

  always_comb
  begin
    state_d = state_q;
    pend_d = pend_q;
    query_d = query_q;
    esr_d = esr_q;
    load = 1'b0;
    text = '0;
    len = '0;
    unique case (state_q)
      // Units keep flowing while a completion waits, so the queue can drain
      // and a status clear or reset can still reach and cancel the request
      ST_IDLE, ST_WAIT:
      begin
        if (take)
        begin
          unique case (unit_in.cmd)
            IOCC_CMD_IDQ:
            begin
              load = 1'b1;
              text = IOCC_ID_TEXT;
              len = 5'(IOCC_ID_LEN);
              if (state_q == ST_IDLE)
              begin
                state_d = ST_SEND;
              end
            end
            IOCC_CMD_OPC, IOCC_CMD_OPCQ:
            begin
              pend_d = 1'b1;
              query_d = query_q || (unit_in.cmd == IOCC_CMD_OPCQ);
              state_d = ST_WAIT;
            end
            IOCC_CMD_ESRQ:
            begin
              load = 1'b1;
              text = dec_text(esr_q);
              len = 5'(IOCC_DEC_DIGITS);
              esr_d = '0;
              if (state_q == ST_IDLE)
              begin
                state_d = ST_SEND;
              end
            end
            IOCC_CMD_CLS:
            begin
              esr_d = '0;
            end
            default:
            begin
            end
          endcase
        end
        // A unit taken this cycle defers completion, so two loads never collide
        if (state_q == ST_WAIT && done_now && !take)
        begin
          esr_d[IOCC_ESR_OPC_BIT] = 1'b1;
          pend_d = 1'b0;
          query_d = 1'b0;
          if (query_q)
          begin
            load = 1'b1;
            text = {IOCC_ASCII_ONE, {(8*IOCC_ID_LEN-8){1'b0}}};
            len = 5'h01;
            state_d = ST_SEND;
          end
          else
          begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_SEND:
      begin
        if (!tx_busy)
        begin
          state_d = ST_IDLE;
        end
      end
    endcase
    // Cancel clears the request and drops ST_WAIT back to ST_IDLE; a completion in the same cycle still sets the event bit and loads any query reply
    if (cancel)
    begin
      pend_d = 1'b0;
      query_d = 1'b0;
      if (state_q == ST_WAIT)
      begin
        state_d = ST_IDLE;
      end
      if (take && unit_in.cmd == IOCC_CMD_CLS)
      begin
        esr_d = '0;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      pend_q <= 1'b0;
      query_q <= 1'b0;
      esr_q <= IOCC_ESR_RESET;
      unit_ready_q <= 1'b0;
      oq_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      pend_q <= pend_d;
      query_q <= query_d;
      esr_q <= esr_d;
      unit_ready_q <= (state_d != ST_SEND) && !load && !tx_busy;
      oq_q <= tx_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply serialiser

  iocc_reply_tx u_tx
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(load),
    .text(text),
    .len(len),
    .oq_ready(oq_ready),
    .oq_byte(tx_byte),
    .busy(tx_busy)
  );

  assign unit_ready = unit_ready_q;
  assign oq_out = oq_q; // Registered copy, one cycle behind the serialiser
  assign esr = esr_q;
  assign opc_pending = pend_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_opc_done;
    state_q == ST_WAIT && done_now && !take && !cancel;
  endsequence

  a_pend_clears: assert property (@(posedge sys_clk) disable iff (rst)
    s_opc_done |=> !pend_q && esr_q[IOCC_ESR_OPC_BIT])
    else $error("completion did not set event bit");
  a_query_reply: assert property (@(posedge sys_clk) disable iff (rst)
    (s_opc_done and query_q) |=> tx_byte.valid && tx_byte.data == IOCC_ASCII_ONE)
    else $error("completion query reply missing");
  a_cancel_idle: assert property (@(posedge sys_clk) disable iff (rst)
    dev_clear |=> !pend_q)
    else $error("device clear left request pending");
  a_no_early_set: assert property (@(posedge sys_clk) disable iff (rst)
    pend_q && !queue_empty && !cancel |=> pend_q)
    else $error("pending cleared before queue empty");
  a_pend_set: assert property (@(posedge sys_clk) disable iff (rst)
    take && unit_in.cmd == IOCC_CMD_OPC && !dev_clear |=> pend_q)
    else $error("pending flag not set");
  a_esr_read: assert property (@(posedge sys_clk) disable iff (rst)
    take && unit_in.cmd == IOCC_CMD_ESRQ && state_q == ST_IDLE |=> esr_q == 8'h00)
    else $error("event status not cleared on read");
  a_cls_clear: assert property (@(posedge sys_clk) disable iff (rst)
    take && unit_in.cmd == IOCC_CMD_CLS |=> !pend_q && esr_q == 8'h00)
    else $error("status clear incomplete");
  a_rst_cancel: assert property (@(posedge sys_clk) disable iff (rst)
    take && unit_in.cmd == IOCC_CMD_RST |=> !pend_q)
    else $error("reset command left request pending");
  a_idn_first: assert property (@(posedge sys_clk) disable iff (rst)
    take && unit_in.cmd == IOCC_CMD_IDQ && state_q == ST_IDLE
    |=> tx_byte.valid && tx_byte.data == IOCC_ID_TEXT[8*IOCC_ID_LEN-1 -: 8])
    else $error("identity reply wrong start");

endmodule : iocc_core

// >>> tb/iocc_host_model.sv
`timescale 1ns/1ps
// Output queue and reply reader of the remote controller
module iocc_host_model
  import iocc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Output queue
  input iocc_byte_t oq_out,
  output logic oq_ready,
  // Reply bytes seen so far
  output logic [8*IOCC_ID_LEN-1:0] rx_q,
  output logic last_q,
  output int n_rx
);
  // Reader stays ready; it accepts a reply byte every cycle
  assign oq_ready = 1'b1;
  ////////////////////////////////////////////////////////////////////////
  // Shift in each delivered byte, newest at the bottom
  always_ff @(posedge sys_clk)
  begin
    if (oq_out.valid)
    begin
      rx_q <= {rx_q[8*IOCC_ID_LEN-9:0], oq_out.data};
      last_q <= oq_out.last;
      n_rx <= n_rx + 1;
    end
  end
endmodule : iocc_host_model

// >>> tb/test_iocc_core.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end
module test_iocc_core
  import iocc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  iocc_unit_t unit_in = '0;
  logic unit_ready, queue_empty = 1'b1, work_busy = 1'b0, dev_clear = 1'b0, oq_ready;
  iocc_byte_t oq_out;
  logic [IOCC_ESR_W-1:0] esr;
  logic opc_pending, last_q;
  logic [8*IOCC_ID_LEN-1:0] rx;
  int n_rx, miscompares = 0, n_compared = 0, cyc = 0, n0;

  iocc_core uut (.sys_clk(sys_clk), .rst(rst), .unit_in(unit_in), .unit_ready(unit_ready),
    .queue_empty(queue_empty), .work_busy(work_busy), .dev_clear(dev_clear),
    .oq_ready(oq_ready), .oq_out(oq_out), .esr(esr), .opc_pending(opc_pending));
  iocc_host_model host (.sys_clk(sys_clk), .rst(rst), .oq_out(oq_out), .oq_ready(oq_ready),
    .rx_q(rx), .last_q(last_q), .n_rx(n_rx));

  always #5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////
  // Watchdog: all tests fit well inside this many cycles
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wait_cyc

  // Present one unit on a falling edge and hold it until it is taken
  task automatic send(input iocc_cmd_t c);
    unit_in = '{valid: 1'b1, cmd: c};
    while (unit_ready !== 1'b1)
      @(negedge sys_clk);
    @(negedge sys_clk);
    unit_in = '0;
  endtask : send

  ////////////////////////////////////////////////////////////////////////
  task automatic t_esr();
    n0 = n_rx;
    send(IOCC_CMD_ESRQ);
    wait_cyc(12);
    `CHK("esr reply len", 3, n_rx - n0)
    `CHK("esr reply", 24'h313238, rx[23:0])
    `CHK("esr after read", 8'h00, esr)
    $display("done esr read");
  endtask : t_esr

  task automatic t_ident();
    n0 = n_rx;
    send(IOCC_CMD_IDQ);
    wait_cyc(2);
    `CHK("ready while reply", 1'b0, unit_ready)
    wait_cyc(22);
    `CHK("id len", 16, n_rx - n0)
    `CHK("id text", "ACME,MODEL1,0,A1", rx)
    `CHK("id last", 1'b1, last_q)
    `CHK("serial field", 8'h30, rx[31:24])
    $display("done ident");
  endtask : t_ident

  // Completion waits for both an empty queue and idle work
  task automatic t_opc();
    queue_empty = 1'b0;
    work_busy = 1'b1;
    send(IOCC_CMD_OPC);
    wait_cyc(4);
    `CHK("pending", 1'b1, opc_pending)
    queue_empty = 1'b1;
    wait_cyc(4);
    `CHK("opc early", 8'h00, esr)
    work_busy = 1'b0;
    wait_cyc(3);
    `CHK("opc set", 8'h01, esr)
    `CHK("pending done", 1'b0, opc_pending)
    $display("done opc");
  endtask : t_opc

  task automatic t_cls();
    send(IOCC_CMD_CLS);
    wait_cyc(3);
    `CHK("cls esr", 8'h00, esr)
    `CHK("cls pending", 1'b0, opc_pending)
    $display("done cls");
  endtask : t_cls

  task automatic t_opcq();
    n0 = n_rx;
    work_busy = 1'b1;
    send(IOCC_CMD_OPCQ);
    wait_cyc(6);
    `CHK("opcq stall", 0, n_rx - n0)
    work_busy = 1'b0;
    wait_cyc(8);
    `CHK("opcq len", 1, n_rx - n0)
    `CHK("opcq byte", 8'h31, rx[7:0])
    `CHK("opcq last", 1'b1, last_q)
    `CHK("opcq esr", 8'h01, esr)
    $display("done opcq");
  endtask : t_opcq

  // Cancel a pending completion: 0 device clear, 1 power-on, 2 status clear, 3 reset command
  task automatic t_cancel(input logic [1:0] how);
    work_busy = 1'b1;
    send(IOCC_CMD_OPC);
    wait_cyc(2);
    `CHK("pending armed", 1'b1, opc_pending)
    if (how == 2'h0)
      dev_clear = 1'b1;
    else if (how == 2'h1)
      rst = 1'b1;
    else if (how == 2'h2)
      send(IOCC_CMD_CLS);
    else
      send(IOCC_CMD_RST);
    wait_cyc(2);
    rst = 1'b0;
    dev_clear = 1'b0;
    work_busy = 1'b0;
    wait_cyc(4);
    `CHK("cancel pending", 1'b0, opc_pending)
    // Power-on restores the reset value; the reset command leaves event status alone
    `CHK("cancel esr", (how == 2'h1 || how == 2'h3) ? 8'h80 : 8'h00, esr)
    $display("done cancel");
  endtask : t_cancel

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    wait_cyc(8);
    rst = 1'b0;
    wait_cyc(3);
    t_esr();
    t_ident();
    t_opc();
    t_cls();
    t_opcq();
    t_cls();
    t_cancel(2'h0);
    t_cancel(2'h2);
    t_cancel(2'h1);
    t_cancel(2'h3);
    print_verdict();
  end
endmodule : test_iocc_core
